// ### rtl/smpp_pkg.sv
// Constants, types and CRC helper for the supply-line programming port.
// Assumes a single 250 MHz clock domain and a 32-bit AHB-Lite register bus.
package smpp_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MEM = 8'h80;

    // Control and status field positions
    localparam int CTRL_DIS_BIT = 0;
    localparam logic CTRL_DIS_RESET = 1'b0;
    localparam int ST_COMM_BIT = 0;
    localparam int ST_AE_BIT = 1;
    localparam int ST_OR_BIT = 2;
    localparam int ST_CS_BIT = 3;
    localparam int ST_BUSY_BIT = 4;
    localparam int ST_HALF_LSB = 16;

    // Frame layout
    localparam logic [1:0] SYNC_CODE = 2'h0;
    localparam logic [5:0] ACCESS_ADDR = 6'h3F;
    localparam logic [15:0] ACCESS_DATA = 16'h62D2;
    localparam logic [4:0] RD_BITS = 5'h0E;
    localparam logic [4:0] WR_BITS = 5'h1E;
    localparam logic [4:0] RD_CRC_N = 5'h0B;
    localparam logic [4:0] WR_CRC_N = 5'h1B;
    localparam logic [4:0] RESP_CRC_N = 5'h16;
    localparam logic [4:0] RESP_LAST = 5'h1A;
    localparam int MEM_WORDS = 32;

    // CRC generator: x^3 + x + 1, preset all ones
    localparam logic [2:0] CRC_POLY = 3'h3;
    localparam logic [2:0] CRC_PRESET = 3'h7;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_MEAS = 2'h1,
        RX_SYNC2 = 2'h2,
        RX_BITS = 2'h3
    } smpp_rx_t;

    typedef enum logic [0:0] {
        TX_IDLE = 1'h0,
        TX_RUN = 1'h1
    } smpp_tx_t;

    typedef struct packed {
        logic dir;
        logic [3:0] mask;
        logic [5:0] addr;
        logic [15:0] data;
        logic [2:0] crc;
    } smpp_frame_t;

    typedef struct packed {
        logic [1:0] id;
        logic bc;
        logic ae;
        logic ovr;
        logic cs;
    } smpp_status_t;

    // CRC over the low n bits of p, MSB first
    function automatic logic [2:0] crc3(input logic [26:0] p, input logic [4:0] n);
        logic [2:0] c;
        logic fb;
        c = CRC_PRESET;
        fb = 1'b0;
        for (int i = 26; i >= 0; i--) begin
            if (i < int'(n)) begin
                fb = p[i] ^ c[2];
                c = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
            end
        end
        return c;
    endfunction

endpackage

// ### rtl/smpp_prog_port.sv
// Supply-line Manchester programming port with AHB-Lite register access.
// Assumes the supply comparator, strap pins and angle PWM source feed it,
// and that a pad ring resolves the open-drain PWM pin from pwm_pad_oe.
//
// Notes on behaviour
// - Mid-cell rise is zero, fall is one.
// - Fields travel most significant bit first.
// - Disable bit set ignores all supply activity.
// - Answer at the bit rate host used.
// - Answer only pulls low or releases.
// - Nothing acted on before access code.
// - Access code enters communication mode.
// - Exit code restores angle output.
// - Entering communication mode stops angle output immediately.
// - Host starts; device answers reads only.
// - Frames open with two zero sync bits.
// - Direction, four-bit mask, six-bit address follow.
// - Writes carry sixteen data bits; reads none.
// - Three-bit CRC ends every command.
// - Die ID from two straps, high pin upper.
// - Access code: all-ones address, word 62D2.
// - Exit code: all-ones address, other word.
// - Response: status, sixteen data bits, CRC.
// - Odd address read zeroes upper byte.
`timescale 1ns/1ps

module smpp_prog_port #(
    parameter int CNT_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic supply_cmp_in,
    input wire logic die_strap_low,
    input wire logic die_strap_high,
    input wire logic angle_pwm_in,
    output logic pwm_pad_o,
    output logic pwm_pad_oe,
    output logic comm_mode
);

    if (CNT_W < 4 || CNT_W > 24) begin : g_chk
        $error("CNT_W must lie between 4 and 24");
    end

    // Pin synchronisers, three stages each
    logic [2:0] sy1_q, sy2_q, sy3_q, lvl_q;
    logic line_prev_q;
    wire [2:0] pins_in = {supply_cmp_in, die_strap_high, die_strap_low};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sy1_q <= 3'h0;
            sy2_q <= 3'h0;
            sy3_q <= 3'h0;
            lvl_q <= 3'h0;
            line_prev_q <= 1'b0;
        end else begin
            sy1_q <= pins_in;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            lvl_q <= (sy2_q & ~(sy2_q ^ sy3_q)) | (lvl_q & (sy2_q ^ sy3_q));
            line_prev_q <= lvl_q[2];
        end
    end

    // Line edges and die identity
    wire line = lvl_q[2];
    wire rise = line & ~line_prev_q;
    wire fall = ~line & line_prev_q;
    wire edge_seen = rise | fall;
    wire [1:0] die_id = lvl_q[1:0];

    // Receiver state
    smpp_pkg::smpp_rx_t rx_state_q;
    logic [CNT_W-1:0] cnt_q, half_q;
    logic [4:0] nbits_q;
    logic [29:0] sr_q;
    logic ctrl_dis_q, comm_q, ae_q, or_q, cs_q;

    // Decision windows derived from the measured half-bit
    wire [CNT_W+1:0] cnt_ext = {2'b00, cnt_q};
    wire [CNT_W+1:0] win = {2'b00, half_q} + {3'b000, half_q[CNT_W-1:1]};
    wire [CNT_W+1:0] tout = win + {2'b00, half_q};
    wire sat = &cnt_q;
    wire mid_edge = (rx_state_q == smpp_pkg::RX_BITS) && edge_seen && (cnt_ext >= win);
    wire tout_hit = (rx_state_q == smpp_pkg::RX_BITS) && !edge_seen && (cnt_ext >= tout);
    wire sync_bad = (rx_state_q == smpp_pkg::RX_SYNC2) && !rise && (fall || cnt_ext >= win);
    wire overflow = mid_edge && (nbits_q == smpp_pkg::WR_BITS);

    // Frame decode
    wire fr_rd = (nbits_q == smpp_pkg::RD_BITS) && sr_q[13];
    wire fr_wr = (nbits_q == smpp_pkg::WR_BITS) && !sr_q[29];
    smpp_pkg::smpp_frame_t fr;
    assign fr = fr_rd ? smpp_pkg::smpp_frame_t'({sr_q[13:3], 16'h0000, sr_q[2:0]}) : smpp_pkg::smpp_frame_t'(sr_q);
    wire [26:0] crc_in = fr_rd ? {16'h0000, sr_q[13:3]} : sr_q[29:3];
    wire [4:0] crc_n = fr_rd ? smpp_pkg::RD_CRC_N : smpp_pkg::WR_CRC_N;
    wire crc_ok = (smpp_pkg::crc3(crc_in, crc_n) == fr.crc);
    wire frame_ok = tout_hit && (fr_rd || fr_wr);
    wire good = frame_ok && crc_ok;
    wire crc_err = frame_ok && !crc_ok;
    wire ae_set = (sync_bad || overflow || (tout_hit && !(fr_rd || fr_wr))) && !ctrl_dis_q;

    // Command classification
    wire is_code = fr_wr && (fr.addr == smpp_pkg::ACCESS_ADDR);
    wire acc_hit = good && is_code && (fr.data == smpp_pkg::ACCESS_DATA);
    wire exit_hit = good && is_code && (fr.data != smpp_pkg::ACCESS_DATA);
    wire bcast = (fr.mask == 4'h0);
    wire selected = bcast || fr.mask[die_id];
    smpp_pkg::smpp_tx_t tx_state_q;
    wire tx_idle = (tx_state_q == smpp_pkg::TX_IDLE);
    wire mwr_en = good && comm_q && fr_wr && !is_code && selected;
    wire rd_go = good && comm_q && fr_rd && selected && tx_idle;
    wire ovr_set = good && !tx_idle;
    wire comm_d = acc_hit ? 1'b1 : (exit_hit ? 1'b0 : comm_q);

    // Manchester cell decoder, timed from the sync bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state_q <= smpp_pkg::RX_IDLE;
            cnt_q <= '0;
            half_q <= '1;
            nbits_q <= 5'h00;
            sr_q <= 30'h0;
        end else if (ctrl_dis_q) begin
            rx_state_q <= smpp_pkg::RX_IDLE;
        end else begin
            case (rx_state_q)
                smpp_pkg::RX_IDLE: begin
                    cnt_q <= '0;
                    if (rise) begin
                        rx_state_q <= smpp_pkg::RX_MEAS;
                    end
                end
                smpp_pkg::RX_MEAS: begin
                    cnt_q <= fall ? '0 : cnt_q + 1'b1;
                    if (fall) begin
                        half_q <= cnt_q + 1'b1;
                        rx_state_q <= smpp_pkg::RX_SYNC2;
                    end else if (sat) begin
                        rx_state_q <= smpp_pkg::RX_IDLE;
                    end
                end
                smpp_pkg::RX_SYNC2: begin
                    cnt_q <= rise ? '0 : cnt_q + 1'b1;
                    nbits_q <= 5'h00;
                    if (rise) begin
                        rx_state_q <= smpp_pkg::RX_BITS;
                    end else if (sync_bad) begin
                        rx_state_q <= smpp_pkg::RX_IDLE;
                    end
                end
                smpp_pkg::RX_BITS: begin
                    if (mid_edge) begin
                        cnt_q <= '0;
                        sr_q <= {sr_q[28:0], ~line};
                        nbits_q <= nbits_q + 5'h01;
                        if (overflow) begin
                            rx_state_q <= smpp_pkg::RX_IDLE;
                        end
                    end else if (tout_hit) begin
                        rx_state_q <= smpp_pkg::RX_IDLE;
                    end else if (!sat) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    rx_state_q <= smpp_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // AHB-Lite address phase capture
    wire ap_take = hsel && htrans[1] && hready;
    logic ap_wr_q, ap_rd_q;
    logic [7:0] ap_addr_q;
    wire ahb_ctrl_wr = ap_wr_q && (ap_addr_q == smpp_pkg::OFF_CTRL);
    wire ahb_mem_wr = ap_wr_q && ap_addr_q[7];

    // Register array shared by the supply link and the bus
    logic [15:0] mem_q [smpp_pkg::MEM_WORDS];
    wire [15:0] rd_word = mem_q[fr.addr[5:1]];
    wire [15:0] rd_data = fr.addr[0] ? {8'h00, rd_word[7:0]} : rd_word;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < smpp_pkg::MEM_WORDS; i++) begin
                mem_q[i] <= 16'h0000;
            end
        end else if (mwr_en && fr.addr[0]) begin
            mem_q[fr.addr[5:1]][7:0] <= fr.data[7:0];
        end else if (mwr_en) begin
            mem_q[fr.addr[5:1]] <= fr.data;
        end else if (ahb_mem_wr) begin
            mem_q[ap_addr_q[6:2]] <= hwdata[15:0];
        end
    end

    // Mode, sticky error flags and control bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comm_q <= 1'b0;
            ae_q <= 1'b0;
            or_q <= 1'b0;
            cs_q <= 1'b0;
            ctrl_dis_q <= smpp_pkg::CTRL_DIS_RESET;
        end else begin
            comm_q <= comm_d;
            ae_q <= ae_set | (ae_q & ~rd_go);
            or_q <= ovr_set | (or_q & ~rd_go);
            cs_q <= crc_err | (cs_q & ~rd_go);
            ctrl_dis_q <= ahb_ctrl_wr ? hwdata[smpp_pkg::CTRL_DIS_BIT] : ctrl_dis_q;
        end
    end

    // Response word: sync, status, data, CRC
    smpp_pkg::smpp_status_t st;
    assign st = '{id: (bcast ? 2'b00 : die_id), bc: bcast, ae: ae_q, ovr: or_q, cs: cs_q};
    wire [21:0] resp_body = {st, rd_data};
    wire [26:0] tx_word = {smpp_pkg::SYNC_CODE, resp_body, smpp_pkg::crc3({5'h00, resp_body}, smpp_pkg::RESP_CRC_N)};

    // Response serialiser at the host's half-bit
    logic [26:0] tx_sr_q;
    logic [4:0] tx_left_q;
    logic [CNT_W-1:0] tx_cnt_q, tx_half_q;
    logic tx_ph_q;
    wire tx_tick = (tx_cnt_q == tx_half_q - 1'b1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state_q <= smpp_pkg::TX_IDLE;
            tx_sr_q <= 27'h0;
            tx_left_q <= 5'h00;
            tx_cnt_q <= '0;
            tx_half_q <= '1;
            tx_ph_q <= 1'b0;
        end else if (tx_idle) begin
            tx_cnt_q <= '0;
            tx_ph_q <= 1'b0;
            if (rd_go) begin
                tx_state_q <= smpp_pkg::TX_RUN;
                tx_sr_q <= tx_word;
                tx_left_q <= smpp_pkg::RESP_LAST;
                tx_half_q <= half_q;
            end
        end else if (!tx_tick) begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
        end else begin
            tx_cnt_q <= '0;
            tx_ph_q <= ~tx_ph_q;
            if (tx_ph_q && tx_left_q == 5'h00) begin
                tx_state_q <= smpp_pkg::TX_IDLE;
            end else if (tx_ph_q) begin
                tx_left_q <= tx_left_q - 5'h01;
                tx_sr_q <= {tx_sr_q[25:0], 1'b0};
            end
        end
    end

    // Open-drain pin: angle output or Manchester answer
    wire tx_level = tx_ph_q ? ~tx_sr_q[26] : tx_sr_q[26];
    wire tx_drive = !tx_idle && !tx_level;
    logic pwm_oe_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_oe_q <= 1'b0;
        end else begin
            pwm_oe_q <= comm_d ? tx_drive : ~angle_pwm_in;
        end
    end

    assign pwm_pad_o = 1'b0;
    assign pwm_pad_oe = pwm_oe_q;
    assign comm_mode = comm_q;

    // Bus read mux, one wait state per read
    logic [31:0] hrdata_q;
    wire [31:0] st_word = {16'(half_q), 11'h000, !tx_idle, cs_q, or_q, ae_q, comm_q};
    wire [31:0] rd_mux = ap_addr_q[7] ? {16'h0000, mem_q[ap_addr_q[6:2]]} :
                         (ap_addr_q == smpp_pkg::OFF_CTRL) ? {31'h0, ctrl_dis_q} :
                         (ap_addr_q == smpp_pkg::OFF_STATUS) ? st_word : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q <= 1'b0;
            ap_rd_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hrdata_q <= 32'h0;
        end else begin
            ap_wr_q <= ap_take && hwrite;
            ap_rd_q <= ap_take && !hwrite;
            ap_addr_q <= ap_take ? haddr[7:0] : ap_addr_q;
            hrdata_q <= ap_rd_q ? rd_mux : hrdata_q;
        end
    end

    assign hreadyout = !ap_rd_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;

    // Checks on the link behaviour
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_pin_never_high: assert property (pwm_pad_o == 1'b0) else $error("PWM pin driven high");
    a_disable_holds_rx: assert property (ctrl_dis_q |=> rx_state_q == smpp_pkg::RX_IDLE)
        else $error("Receiver active while disabled");
    a_write_needs_mode: assert property (good && fr_wr && !comm_q && !ahb_mem_wr |=>
        mem_q[$past(fr.addr[5:1])] == $past(mem_q[fr.addr[5:1]]))
        else $error("Write executed before access code");
    a_access_enters: assert property (acc_hit |=> comm_q && comm_mode) else $error("Access code ignored");
    a_exit_leaves: assert property (exit_hit |=> !comm_q) else $error("Exit code ignored");
    a_angle_stopped: assert property (comm_q && $past(tx_state_q) == smpp_pkg::TX_IDLE |-> !pwm_pad_oe)
        else $error("Angle output seen in communication mode");
    a_resp_rate: assert property (rd_go |=> tx_half_q == $past(half_q) && tx_state_q == smpp_pkg::TX_RUN)
        else $error("Response rate differs from command rate");
    a_resp_sync: assert property (rd_go |=> tx_sr_q[26:25] == 2'b00 ##1 pwm_pad_oe [*2])
        else $error("Response does not open with zero sync");
    a_odd_upper_zero: assert property (rd_go && fr.addr[0] |=> tx_sr_q[18:11] == 8'h00)
        else $error("Odd read carries upper byte");
    a_bad_crc_flag: assert property (crc_err |=> cs_q && $stable(comm_q))
        else $error("CRC error not recorded or acted on");
    a_select_mask: assert property (frame_ok && crc_ok && fr_rd && tx_idle && fr.mask != 4'h0 &&
        !fr.mask[die_id] |=> tx_idle)
        else $error("Unselected die answers");

    c_access: cover property (acc_hit);
    c_write: cover property (mwr_en);
    c_read_done: cover property (tx_state_q == smpp_pkg::TX_RUN ##1 tx_idle);
    c_abort: cover property (ae_set);

endmodule

// ### verif/smpp_host_model.sv
// Behavioural programming controller that drives the supply line and listens on the return line.
// Assumes the device's hclk and a pull-up on the open-drain return line.
`timescale 1ns/1ps

module smpp_host_model (
    input wire logic hclk,
    input wire logic pwm_pad_oe,
    output logic supply_cmp_in
);
    // Pulled-up return line, low only while the device sinks it
    wire logic line = !pwm_pad_oe;

    // Supply rests low between frames
    initial supply_cmp_in = 1'b0;

    // Check value: x^3+x+1, preset all ones, MSB first
    function automatic logic [2:0] crc_of(input logic [26:0] p, input int n);
        logic [2:0] c;
        logic fb;
        c = 3'h7;
        for (int i = n - 1; i >= 0; i--) begin
            fb = p[i] ^ c[2];
            c = {c[1:0], 1'b0} ^ (fb ? 3'h3 : 3'h0);
        end
        return c;
    endfunction

    // Host-started frame, any mask including broadcast, h cycles per half cell
    task automatic send(input logic dir, input logic [3:0] mask, input logic [5:0] addr,
                        input logic [15:0] data, input int h, input logic flip);
        logic [26:0] p;
        logic [31:0] f;
        int n;
        p = dir ? {16'h0000, dir, mask, addr} : {dir, mask, addr, data};
        n = dir ? 11 : 27;
        f = {2'b00, p, 3'h0} | {29'h0, crc_of(p, n) ^ {2'b00, flip}};
        repeat (3 * h) @(posedge hclk);
        for (int i = n + 4; i >= 0; i--) begin
            supply_cmp_in <= f[i];
            repeat (h) @(posedge hclk);
            supply_cmp_in <= !f[i];
            repeat (h) @(posedge hclk);
        end
        supply_cmp_in <= 1'b0;
        repeat (4 * h) @(posedge hclk);
    endtask

    // Cut frame: sync and a few zero cells, then silence
    task automatic send_cut(input int cells, input int h);
        repeat (3 * h) @(posedge hclk);
        repeat (cells + 2) begin
            supply_cmp_in <= 1'b0;
            repeat (h) @(posedge hclk);
            supply_cmp_in <= 1'b1;
            repeat (h) @(posedge hclk);
        end
        supply_cmp_in <= 1'b0;
        repeat (4 * h) @(posedge hclk);
    endtask

    // Collects a 27-cell answer, sampling the middle of each first half
    task automatic get_resp(input int h, output logic [26:0] r);
        int k;
        k = 0;
        r = '0;
        while (line !== 1'b0 && k < 4000) begin
            @(posedge hclk);
            k++;
        end
        repeat (h / 2) @(posedge hclk);
        for (int i = 26; i >= 0; i--) begin
            r[i] = line;
            repeat (2 * h) @(posedge hclk);
        end
    endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench: register access over AHB-Lite, commands through the host model.
// Assumes one 250 MHz clock and a die strapped to ID two.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module tb_top;
    logic hclk, hresetn, hsel, hwrite, supply_cmp_in, die_strap_low, die_strap_high, angle_pwm_in;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, pwm_pad_o, pwm_pad_oe, comm_mode;
    int num_errors = 0;
    int samples_checked = 0;

    smpp_prog_port smpp_prog_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .supply_cmp_in(supply_cmp_in),
        .die_strap_low(die_strap_low), .die_strap_high(die_strap_high), .angle_pwm_in(angle_pwm_in),
        .pwm_pad_o(pwm_pad_o), .pwm_pad_oe(pwm_pad_oe), .comm_mode(comm_mode));

    smpp_host_model smpp_host_model_inst (.hclk(hclk), .pwm_pad_oe(pwm_pad_oe), .supply_cmp_in(supply_cmp_in));

    // 4 ns clock
    always #2 hclk = ~hclk;

    // Single AHB-Lite transfer, address phase then data phase
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    task automatic bus_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, q);
        `CHK(q & m, exp)
    endtask

    // Read command with its answer checked cell by cell
    task automatic rd_chk(input logic [3:0] mask, input logic [5:0] addr, input int h,
                          input logic [5:0] st, input logic [15:0] data);
        logic [26:0] r;
        fork
            smpp_host_model_inst.send(1'b1, mask, addr, 16'h0000, h, 1'b0);
            smpp_host_model_inst.get_resp(h, r);
        join
        `CHK(r, {2'b00, st, data, smpp_host_model_inst.crc_of({5'h0, st, data}, 22)})
        `CHK(pwm_pad_o, 1'b0)
        bus_chk(smpp_pkg::OFF_STATUS, {16'(h), 16'h0001}, 32'hFFFF001F);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard well beyond the expected run length
    initial begin
        repeat (60000) @(posedge hclk);
        num_errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        die_strap_low = 1'b0;
        die_strap_high = 1'b1;
        angle_pwm_in = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        `CHK(hresp, 1'b0)
        `CHK(pwm_pad_oe, 1'b1)
        bus_chk(smpp_pkg::OFF_CTRL, 32'h0, 32'h1);
        bus_chk(smpp_pkg::OFF_STATUS, 32'h0, 32'h1F);
        bus_wr(smpp_pkg::OFF_MEM + 8'h04, 32'h1111);
        bus_wr(smpp_pkg::OFF_MEM + 8'h0C, 32'h3333);
        bus_chk(8'h40, 32'h0, 32'hFFFFFFFF);
        // Commands before the access code and while disabled do nothing
        smpp_host_model_inst.send(1'b0, 4'h0, 6'h02, 16'hABCD, 10, 1'b0);
        bus_chk(smpp_pkg::OFF_MEM + 8'h04, 32'h1111, 32'hFFFFFFFF);
        bus_wr(smpp_pkg::OFF_CTRL, 32'h1);
        smpp_host_model_inst.send(1'b0, 4'h2, 6'h3F, 16'h62D2, 10, 1'b0);
        `CHK(comm_mode, 1'b0)
        bus_wr(smpp_pkg::OFF_CTRL, 32'h0);
        // Access code with a mask that does not select this die
        smpp_host_model_inst.send(1'b0, 4'h2, 6'h3F, 16'h62D2, 10, 1'b0);
        `CHK(comm_mode, 1'b1)
        `CHK(pwm_pad_oe, 1'b0)
        // Selected, unselected, broadcast and corrupted writes
        smpp_host_model_inst.send(1'b0, 4'h4, 6'h04, 16'h1234, 10, 1'b0);
        smpp_host_model_inst.send(1'b0, 4'hB, 6'h06, 16'h5555, 12, 1'b0);
        smpp_host_model_inst.send(1'b0, 4'h0, 6'h08, 16'h9ABC, 12, 1'b0);
        smpp_host_model_inst.send(1'b0, 4'h4, 6'h02, 16'h7777, 10, 1'b1);
        bus_chk(smpp_pkg::OFF_MEM + 8'h08, 32'h1234, 32'hFFFFFFFF);
        bus_chk(smpp_pkg::OFF_MEM + 8'h0C, 32'h3333, 32'hFFFFFFFF);
        bus_chk(smpp_pkg::OFF_MEM + 8'h10, 32'h9ABC, 32'hFFFFFFFF);
        bus_chk(smpp_pkg::OFF_MEM + 8'h04, 32'h1111, 32'hFFFFFFFF);
        bus_chk(smpp_pkg::OFF_STATUS, 32'h9, 32'h1F);
        smpp_host_model_inst.send_cut(5, 10);
        bus_chk(smpp_pkg::OFF_STATUS, 32'hB, 32'h1F);
        // Reads at different rates, even, odd and broadcast
        rd_chk(4'h4, 6'h04, 10, 6'h25, 16'h1234);
        rd_chk(4'h4, 6'h05, 16, 6'h20, 16'h0034);
        rd_chk(4'h0, 6'h08, 12, 6'h08, 16'h9ABC);
        // Unselected read gets no answer; a read during an answer is an overrun
        smpp_host_model_inst.send(1'b1, 4'h1, 6'h04, 16'h0000, 10, 1'b0);
        bus_chk(smpp_pkg::OFF_STATUS, 32'h1, 32'h1F);
        smpp_host_model_inst.send(1'b1, 4'h4, 6'h04, 16'h0000, 10, 1'b0);
        smpp_host_model_inst.send(1'b1, 4'h4, 6'h04, 16'h0000, 10, 1'b0);
        repeat (200) @(posedge hclk);
        bus_chk(smpp_pkg::OFF_STATUS, 32'h5, 32'h1F);
        // Exit code gives the pin back to the angle output
        smpp_host_model_inst.send(1'b0, 4'h1, 6'h3F, 16'h0000, 10, 1'b0);
        `CHK(comm_mode, 1'b0)
        `CHK(pwm_pad_oe, 1'b1)
        angle_pwm_in <= 1'b1;
        repeat (2) @(posedge hclk);
        `CHK(pwm_pad_oe, 1'b0)
        report_and_stop();
    end
endmodule
